/* File: include/wbi_pkg.sv */
// package: constants and functions for the processor write bus and write buffer
package wbi_pkg;
    localparam int ADW = 64;
    localparam int CMDW = 9;
    localparam int BEW = 8;
    // command field positions
    localparam int CMD_KIND_HI = 8;
    localparam int CMD_KIND_LO = 5;
    localparam logic [3:0] CMD_KIND_WRITE = 4'h2;
    localparam logic [CMDW-1:0] CMD_BLOCK8_WR = 9'h051;
    localparam logic [CMDW-1:0] CMD_DATA_LAST = 9'h010;
    localparam logic [CMDW-1:0] CMD_DATA_MORE = 9'h000;
    // single write size field: command bits 2:0 give byte count minus one
    localparam int CMD_SIZE_HI = 2;
    localparam int CMD_SIZE_LO = 0;
    localparam int CMD_BLOCK_BIT = 4;
    localparam int CMD_LAST_BIT = 4;
    localparam logic [CMDW-1:0] CMD_SINGLE_WR_BASE = 9'h048;
    localparam int DW_BYTES = 8;
    localparam logic [ADW-1:0] DW_STEP = 64'h0000000000000008;
    localparam int PAT_W = 4;
    localparam int RDY_LAG = 2;
    localparam int RCLK_LEAD_PCT = 25;
    localparam real CLK_PERIOD_NS = 5.0;
    localparam logic [PAT_W-1:0] PAT_RESERVED_MIN = 4'h9;
    localparam logic [CMDW-1:0] CMD_IDLE = 9'h000;

    // data rate pattern: bitmask of data slots, period in clocks
    function automatic logic [7:0] pat_mask(input logic [PAT_W-1:0] code);
        case (code)
            4'h0: pat_mask = 8'h01;
            4'h1: pat_mask = 8'h03;
            4'h2: pat_mask = 8'h03;
            4'h3: pat_mask = 8'h05;
            4'h4: pat_mask = 8'h03;
            4'h5: pat_mask = 8'h03;
            4'h6: pat_mask = 8'h09;
            4'h7: pat_mask = 8'h03;
            4'h8: pat_mask = 8'h11;
            default: pat_mask = 8'h01;
        endcase
    endfunction

    function automatic logic [3:0] pat_len(input logic [PAT_W-1:0] code);
        case (code)
            4'h0: pat_len = 4'h1;
            4'h1: pat_len = 4'h3;
            4'h2: pat_len = 4'h4;
            4'h3: pat_len = 4'h4;
            4'h4: pat_len = 4'h5;
            4'h5: pat_len = 4'h6;
            4'h6: pat_len = 4'h6;
            4'h7: pat_len = 4'h8;
            4'h8: pat_len = 4'h8;
            default: pat_len = 4'h1;
        endcase
    endfunction

    // byte lane enables from size and low address, both endians
    function automatic logic [BEW-1:0] lane_en(input logic [2:0] sz_m1, input logic [2:0] off,
                                               input logic big_end);
        logic [BEW-1:0] m;
        logic [3:0] lo;
        m = 8'h00;
        lo = big_end ? (4'(DW_BYTES) - 4'(off) - 4'(sz_m1) - 4'h1) : 4'(off);
        for (int i = 0; i < BEW; i++) begin
            if (4'(i) >= lo && 4'(i) <= lo + 4'(sz_m1)) begin
                m[i] = 1'b1;
            end
        end
        lane_en = m;
    endfunction
endpackage

/* File: include/wbi_if.sv */
// interface: processor system write bus between cpu end and buffer end
`timescale 1ns/1ps
`default_nettype none
interface wbi_if;
    import wbi_pkg::*;
    logic [ADW-1:0] address_data_bus;
    logic [CMDW-1:0] system_command_bus;
    logic out_valid_strobe;
    logic write_accept_ready;
    logic read_accept_ready;
    modport cpu (output address_data_bus, output system_command_bus, output out_valid_strobe,
                 input write_accept_ready, input read_accept_ready);
    modport buf_end (input address_data_bus, input system_command_bus, input out_valid_strobe,
                     output write_accept_ready, output read_accept_ready);
endinterface
`default_nettype wire

/* File: hdl/wbi_cpu_end.sv */
// cpu end: issues single and block writes on the multiplexed bus
// ****************************************************************
// Function
// R1: buffer takes writes on strobe plus command
// R2: block write command is 001010001
// R3: buffer holds ready low when not able
// R4: ready acted on two clocks later
// R5: base address with the write command
// R6: block data in rising doubleword order
// R7: buffer latches and increments address
// R8: first data after variable delay
// R9: remaining data follow reset pattern
// R10: no idle guaranteed after last data
// R11: buffer absorbs data it cannot retire
// R12: buffer reports write errors externally
// R13: narrow writes drive all byte lanes
// R14: buffer holds whole largest block; code takes a block with up to 6 words queued, overrunning its 8 entries
// R15: buffer depth equals block size; DEPTH is 8, twice the 4-word block
// R16: dynamic memory holds ready during precharge
// R17: buffer builds lane enables from command
// R18: no unaligned writes
// R19: five-to-eight bytes anchor at 0 or 7
// R20: one-to-four bytes anchor at 0 or 3
// R21: early receive clock leads by quarter; code has no receive clock, both ends use the rising clock edge
// R22: pattern code selects data rhythm
// R23: buffer drops read ready during write
// R24: buffer retires in order, flags full
// ****************************************************************
`timescale 1ns/1ps
`default_nettype none
module wbi_cpu_end
    import wbi_pkg::*;
#(
    parameter int BLOCK_WORDS = 4
) (
    input wire logic clock,
    input wire logic rst,
    wbi_if.cpu bus,
    input wire logic [PAT_W-1:0] pattern_code,
    input wire logic big_endian,
    input wire logic req_valid,
    output logic req_ready,
    input wire logic req_block,
    input wire logic [ADW-1:0] req_addr,
    input wire logic [2:0] req_size_m1,
    input wire logic [3:0] req_first_gap,
    input wire logic [BLOCK_WORDS*ADW-1:0] req_data,
    output logic busy
);
    typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_GAP, ST_DATA} wbi_cst_t;
    typedef struct packed {
        wbi_cst_t st;
        logic [PAT_W-1:0] pat;
        logic rdy1;
        logic [1:0] hold;
        logic block;
        logic [ADW-1:0] addr;
        logic [2:0] sz;
        logic [3:0] gap;
        logic [BLOCK_WORDS*ADW-1:0] data;
        logic [4:0] idx;
        logic [3:0] phase;
        logic [ADW-1:0] ad;
        logic [CMDW-1:0] cmd;
        logic vld;
        logic [ADW-1:0] junk;
    } wbi_cstate_t;

    wbi_cstate_t s_r;
    wbi_cstate_t s_nxt;
    logic [2:0] off;
    logic [2:0] asz;
    logic [7:0] pm;

    function automatic logic [CMDW-1:0] size_cmd(input logic [2:0] sz);
        size_cmd = {6'h00, sz};
    endfunction

    // alignment: clamp low address so access stays in one word or doubleword
    always_comb begin
        asz = req_size_m1;
        off = req_addr[2:0];
        if (asz >= 3'h4) begin
            off = 3'h0; // R18 R19
        end else begin
            off = {req_addr[2], 2'h0}; // R18 R20
        end
    end

    // ****************************************************************
    // transaction engine
    // ****************************************************************
    always_comb begin
        s_nxt = s_r;
        s_nxt.rdy1 = bus.write_accept_ready; // R4
        s_nxt.vld = 1'b0;
        s_nxt.cmd = CMD_IDLE;
        pm = pat_mask(s_r.pat);
        case (s_r.st)
            ST_IDLE: begin
                if (req_valid) begin
                    s_nxt.block = req_block;
                    s_nxt.sz = asz;
                    s_nxt.gap = req_first_gap;
                    s_nxt.data = req_data;
                    s_nxt.idx = 5'h00;
                    s_nxt.addr = req_block ? {req_addr[ADW-1:3], 3'h0}
                                           : {req_addr[ADW-1:3], off};
                    s_nxt.hold = 2'h0;
                    s_nxt.st = ST_ADDR;
                end else begin
                    s_nxt.pat = (pattern_code >= PAT_RESERVED_MIN) ? 4'h0 : pattern_code; // R22
                end
            end
            ST_ADDR: begin
                s_nxt.vld = 1'b1;
                s_nxt.ad = s_r.addr; // R5
                s_nxt.cmd = s_r.block ? CMD_BLOCK8_WR
                                      : (CMD_SINGLE_WR_BASE | size_cmd(s_r.sz)); // R2
                if (s_r.hold != 2'(RDY_LAG - 1)) begin
                    s_nxt.hold = s_r.hold + 2'h1;
                end else if (s_r.rdy1) begin
                    s_nxt.st = ST_GAP; // R4
                end
            end
            ST_GAP: begin
                s_nxt.ad = s_r.junk;
                if (s_r.gap == 4'h0) begin
                    s_nxt.phase = 4'h0;
                    s_nxt.st = ST_DATA; // R8
                end else begin
                    s_nxt.gap = s_r.gap - 4'h1;
                end
            end
            ST_DATA: begin
                s_nxt.phase = (s_r.phase + 4'h1 >= pat_len(s_r.pat)) ? 4'h0 : s_r.phase + 4'h1;
                if (s_r.idx == 5'h00 || pm[s_r.phase[2:0]]) begin // R9 R22
                    s_nxt.vld = 1'b1;
                    s_nxt.ad = s_r.data[ADW-1:0]; // R6
                    s_nxt.data = s_r.data >> ADW;
                    s_nxt.junk = s_r.data[ADW-1:0]; // R13
                    s_nxt.idx = s_r.idx + 5'h01;
                    s_nxt.cmd = (!s_r.block || s_r.idx == 5'(BLOCK_WORDS - 1))
                                ? CMD_DATA_LAST : CMD_DATA_MORE;
                    if (s_nxt.cmd == CMD_DATA_LAST) begin
                        s_nxt.st = ST_IDLE; // R10
                    end
                end
            end
            default: s_nxt.st = ST_IDLE;
        endcase
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign req_ready = (s_r.st == ST_IDLE);
    assign busy = (s_r.st != ST_IDLE);
    assign bus.address_data_bus = s_r.ad;
    assign bus.system_command_bus = s_r.cmd;
    assign bus.out_valid_strobe = s_r.vld;
endmodule
`default_nettype wire

/* File: hdl/wbi_buf_end.sv */
// buffer end: captures writes, increments address, queues words to memory
`timescale 1ns/1ps
`default_nettype none
module wbi_buf_end
    import wbi_pkg::*;
#(
    parameter int DEPTH = 8,
    parameter int AW = 3
) (
    input wire logic clock,
    input wire logic rst,
    wbi_if.buf_end bus,
    input wire logic big_endian,
    input wire logic mem_busy,
    output logic mem_valid,
    input wire logic mem_ready,
    output logic [ADW-1:0] mem_addr,
    output logic [ADW-1:0] mem_data,
    output logic [BEW-1:0] mem_be,
    input wire logic mem_error,
    output logic err_irq,
    output logic [ADW-1:0] err_addr,
    output logic [ADW-1:0] err_data
);
    typedef enum logic [1:0] {SB_IDLE, SB_DATA} wbi_bst_t;
    typedef struct packed {
        wbi_bst_t st;
        logic [ADW-1:0] addr;
        logic [BEW-1:0] be;
        logic [DEPTH-1:0][ADW-1:0] qa;
        logic [DEPTH-1:0][ADW-1:0] qd;
        logic [DEPTH-1:0][BEW-1:0] qb;
        logic [AW:0] wp;
        logic [AW:0] rp;
        logic irq;
        logic [ADW-1:0] ea;
        logic [ADW-1:0] ed;
    } wbi_bstate_t;

    wbi_bstate_t s_r;
    wbi_bstate_t s_nxt;
    logic [AW:0] used;
    logic full;
    logic is_wr;

    always_comb begin
        used = s_r.wp - s_r.rp;
        full = used >= (AW+1)'(DEPTH - 1); // R24
        is_wr = bus.out_valid_strobe
                && bus.system_command_bus[CMD_KIND_HI:CMD_KIND_LO] == CMD_KIND_WRITE; // R1
    end

    // ****************************************************************
    // capture and retire
    // ****************************************************************
    always_comb begin
        s_nxt = s_r;
        case (s_r.st)
            SB_IDLE: begin
                if (is_wr && !full && !mem_busy) begin // R3
                    s_nxt.addr = bus.address_data_bus; // R7
                    s_nxt.be = bus.system_command_bus[CMD_BLOCK_BIT] ? 8'hFF
                        : lane_en(bus.system_command_bus[CMD_SIZE_HI:CMD_SIZE_LO],
                                  bus.address_data_bus[2:0], big_endian); // R17
                    s_nxt.st = SB_DATA;
                end
            end
            SB_DATA: begin
                if (bus.out_valid_strobe && !is_wr) begin // R8 R11
                    s_nxt.qa[s_r.wp[AW-1:0]] = {s_r.addr[ADW-1:3], 3'h0};
                    s_nxt.qd[s_r.wp[AW-1:0]] = bus.address_data_bus;
                    s_nxt.qb[s_r.wp[AW-1:0]] = s_r.be;
                    s_nxt.wp = s_r.wp + (AW+1)'(1); // R14 R15
                    s_nxt.addr = s_r.addr + DW_STEP; // R7
                    if (bus.system_command_bus[CMD_LAST_BIT]) begin
                        s_nxt.st = SB_IDLE; // R10
                    end
                end
            end
            default: s_nxt.st = SB_IDLE;
        endcase
        if (mem_valid && mem_ready) begin
            s_nxt.rp = s_r.rp + (AW+1)'(1); // R24
            if (mem_error) begin
                s_nxt.irq = 1'b1; // R12
                s_nxt.ea = mem_addr;
                s_nxt.ed = mem_data;
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin // R21
        if (rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ready low while full or dynamic memory busy
    assign bus.write_accept_ready = !full && !mem_busy && s_r.st == SB_IDLE; // R3 R16
    assign bus.read_accept_ready = (used == '0) && !is_wr; // R23
    assign mem_valid = (used != '0);
    assign mem_addr = s_r.qa[s_r.rp[AW-1:0]];
    assign mem_data = s_r.qd[s_r.rp[AW-1:0]];
    assign mem_be = s_r.qb[s_r.rp[AW-1:0]];
    assign err_irq = s_r.irq;
    assign err_addr = s_r.ea;
    assign err_data = s_r.ed;
endmodule
`default_nettype wire

/* File: test/wbi_bus_asserts.sv */
// checker: interface-level assertions for the processor write bus
`timescale 1ns/1ps
`default_nettype none
module wbi_bus_asserts
    import wbi_pkg::*;
#(
    parameter int BLOCK_WORDS = 4
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic [ADW-1:0] address_data_bus,
    input wire logic [CMDW-1:0] system_command_bus,
    input wire logic out_valid_strobe,
    input wire logic write_accept_ready,
    input wire logic read_accept_ready
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    logic blk_w, sgl_w, adp, dat_c, dat, blk_r;
    logic [3:0] cnt_r;
    assign blk_w = system_command_bus == CMD_BLOCK8_WR;
    assign sgl_w = system_command_bus[8:3] == CMD_SINGLE_WR_BASE[8:3];
    assign adp = out_valid_strobe && (blk_w || sgl_w);
    assign dat_c = system_command_bus == CMD_DATA_MORE || system_command_bus == CMD_DATA_LAST;
    assign dat = out_valid_strobe && dat_c;
    // data items counted since the address phase
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cnt_r <= 4'h0;
            blk_r <= 1'b0;
        end else if (adp) begin
            cnt_r <= 4'h0;
            blk_r <= blk_w;
        end else if (dat) begin
            cnt_r <= cnt_r + 4'h1;
        end
    end
    a_cmd_legal: assert property (out_valid_strobe |-> (blk_w || sgl_w || dat_c))
        else $error("strobe with unknown command");
    a_addr_hold: assert property ($rose(adp) |-> adp ##1 (adp && $stable(address_data_bus)))
        else $error("address phase dropped early");
    a_wait_ready: assert property (adp && !$past(write_accept_ready)
        && !$past(write_accept_ready, 2) |=> adp)
        else $error("address phase ended without ready");
    a_first_data: assert property ($fell(adp) |-> ##[0:40] dat)
        else $error("no data after address");
    a_block_count: assert property (dat && system_command_bus == CMD_DATA_LAST
        |-> cnt_r == (blk_r ? 4'(BLOCK_WORDS - 1) : 4'h0))
        else $error("wrong number of data items");
    a_data_gap: assert property (dat && system_command_bus == CMD_DATA_MORE
        |=> !out_valid_strobe ##1 dat)
        else $error("data rhythm broken");
    a_ready_reset: assert property ($fell(rst) |-> write_accept_ready && read_accept_ready)
        else $error("ready low after reset");
    a_no_unaligned: assert property (adp && sgl_w
        |-> {1'b0, address_data_bus[2:0]} + {1'b0, system_command_bus[2:0]} <= 4'h7)
        else $error("single write crosses doubleword");
endmodule
`default_nettype wire

/* File: test/cpu_write_buffer_interface_bench.sv */
// testbench: both write bus ends joined, memory side driven here
`timescale 1ns/1ps
`default_nettype none
module cpu_write_buffer_interface_bench;
    import wbi_pkg::*;
    logic clock, rst, big_endian, req_valid, req_block, mem_busy, mem_ready, mem_error;
    logic req_ready, busy, mem_valid, err_irq;
    logic [3:0] pattern_code, req_first_gap;
    logic [2:0] req_size_m1;
    logic [63:0] req_addr, mem_addr, mem_data, err_addr, err_data;
    logic [255:0] req_data;
    logic [7:0] mem_be;
    logic [132:0] got_q[$];
    int fail_count, num_checks, cyc;
    wbi_if i_wbi_if ();
    wbi_cpu_end #(.BLOCK_WORDS(4)) i_wbi_cpu_end (.clock(clock), .rst(rst),
        .bus(i_wbi_if.cpu), .pattern_code(pattern_code), .big_endian(big_endian),
        .req_valid(req_valid), .req_ready(req_ready), .req_block(req_block),
        .req_addr(req_addr), .req_size_m1(req_size_m1), .req_first_gap(req_first_gap),
        .req_data(req_data), .busy(busy));
    wbi_buf_end #(.DEPTH(8), .AW(3)) i_wbi_buf_end (.clock(clock), .rst(rst),
        .bus(i_wbi_if.buf_end), .big_endian(big_endian), .mem_busy(mem_busy),
        .mem_valid(mem_valid), .mem_ready(mem_ready), .mem_addr(mem_addr),
        .mem_data(mem_data), .mem_be(mem_be), .mem_error(mem_error), .err_irq(err_irq),
        .err_addr(err_addr), .err_data(err_data));
    wbi_bus_asserts #(.BLOCK_WORDS(4)) i_wbi_bus_asserts (.clock(clock), .rst(rst),
        .address_data_bus(i_wbi_if.address_data_bus),
        .system_command_bus(i_wbi_if.system_command_bus),
        .out_valid_strobe(i_wbi_if.out_valid_strobe),
        .write_accept_ready(i_wbi_if.write_accept_ready),
        .read_accept_ready(i_wbi_if.read_accept_ready));
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    always @(posedge clock) begin
        cyc++;
        if (!rst && mem_valid === 1'b1 && mem_ready === 1'b1) begin
            got_q.push_back({mem_addr[63:3], mem_data, mem_be});
        end
        if (cyc == 30000) begin
            fail_count++;
            complete_run();
        end
    end
    task automatic complete_run;
        $display("checks %0d errors %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic check(input string nm, input logic [132:0] seen, input logic [132:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // issue one request at a falling edge
    task automatic issue(input logic b, input logic [63:0] a, input logic [2:0] s,
                         input logic [255:0] d);
        int n;
        n = 0;
        while (req_ready !== 1'b1 && n < 300) begin
            @(negedge clock);
            n++;
        end
        req_valid = 1'b1;
        req_block = b;
        req_addr = a;
        req_size_m1 = s;
        req_data = d;
        @(negedge clock);
        req_valid = 1'b0;
    endtask
    task automatic expw(input logic [63:0] a, input logic [63:0] d, input logic [7:0] be);
        int n;
        n = 0;
        while (got_q.size() == 0 && n < 300) begin
            @(negedge clock);
            n++;
        end
        check("mem_word", got_q.size() > 0 ? got_q.pop_front() : '0, {a[63:3], d, be});
    endtask
    task automatic t_single;
        logic [2:0] off;
        logic [3:0] lo;
        for (int e = 0; e < 2; e++) begin
            for (int s = 0; s < 8; s++) begin
                big_endian = e[0];
                off = s > 3 ? 3'h0 : 3'h4;
                lo = e[0] ? 4'(7 - int'(off) - s) : 4'(off);
                issue(1'b0, 64'h1000 + 64'(off), 3'(s), {192'h0, 64'hA5A5 + 64'(s)});
                expw(64'h1000, 64'hA5A5 + 64'(s), 8'(((16'h1 << (s + 1)) - 16'h1) << lo));
            end
        end
        big_endian = 1'b0;
    endtask
    task automatic t_block;
        logic [255:0] d;
        for (int k = 0; k < 4; k++) begin
            d[k*64 +: 64] = 64'hB000 + 64'(k);
        end
        mem_ready = 1'b0;
        issue(1'b1, 64'h2000, 3'h7, d);
        issue(1'b1, 64'h3000, 3'h7, d);
        repeat (60) @(negedge clock);
        check("ready_full", {132'h0, i_wbi_if.write_accept_ready}, '0);
        check("rd_ready", {132'h0, i_wbi_if.read_accept_ready}, '0);
        mem_ready = 1'b1;
        for (int k = 0; k < 8; k++) begin
            expw((k < 4 ? 64'h2000 : 64'h3000) + 64'(8 * (k % 4)), 64'hB000 + 64'(k % 4),
                 8'hFF);
        end
    endtask
    task automatic t_busy;
        mem_busy = 1'b1;
        repeat (3) @(negedge clock);
        check("ready_busy", {132'h0, i_wbi_if.write_accept_ready}, '0);
        issue(1'b0, 64'h4000, 3'h7, {192'h0, 64'hC0DE});
        repeat (10) @(negedge clock);
        check("no_word", 133'(got_q.size()), '0);
        check("cpu_busy", {132'h0, busy}, 133'h1);
        mem_busy = 1'b0;
        expw(64'h4000, 64'hC0DE, 8'hFF);
    endtask
    task automatic t_error;
        mem_error = 1'b1;
        issue(1'b0, 64'h5008, 3'h7, {192'h0, 64'hE77});
        expw(64'h5008, 64'hE77, 8'hFF);
        mem_error = 1'b0;
        issue(1'b0, 64'h6000, 3'h7, {192'h0, 64'h1});
        expw(64'h6000, 64'h1, 8'hFF);
        check("err_rec", {err_irq, err_addr[63:3], err_data, 8'h00},
              {1'b1, 61'(64'h5008 >> 3), 64'hE77, 8'h00});
    endtask
    initial begin
        rst = 1'b1;
        big_endian = 1'b0;
        req_valid = 1'b0;
        req_block = 1'b0;
        req_addr = 64'h0;
        req_size_m1 = 3'h0;
        req_data = '0;
        pattern_code = 4'h3;
        req_first_gap = 4'h2;
        mem_busy = 1'b0;
        mem_ready = 1'b1;
        mem_error = 1'b0;
        repeat (2) @(posedge clock);
        @(negedge clock);
        rst = 1'b0;
        t_single();
        t_block();
        t_busy();
        t_error();
        complete_run();
    end
endmodule
`default_nettype wire
